// ### common/composer_pkg.sv
// Purpose: Constants and types shared by the frequency setpoint composer.
// Assumes: Frequencies are integers in units of the selected resolution.
// Notes: Percent inputs use 0.1 % steps, so 1000 means 100.0 %.
`default_nettype none
package composer_pkg;
   localparam logic [7:0] OFS_MAIN_SEL = 8'h00;
   localparam logic [7:0] OFS_AUX_SEL = 8'h04;
   localparam logic [7:0] OFS_AUX_BASE = 8'h08;
   localparam logic [7:0] OFS_AUX_PCT = 8'h0c;
   localparam logic [7:0] OFS_COMPOSE = 8'h10;
   localparam logic [7:0] OFS_PRESET = 8'h14;
   localparam logic [7:0] OFS_DIR_INV = 8'h18;
   localparam logic [7:0] OFS_MAX_FREQ = 8'h1c;
   localparam logic [7:0] OFS_OFFSET = 8'h20;
   localparam logic [7:0] OFS_DECIMALS = 8'h24;
   localparam logic [7:0] OFS_TARGET = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2c;
   localparam logic [7:0] OFS_CONTROL = 8'h30;
   localparam int UNITS_LSB = 0;
   localparam int TENS_LSB = 4;
   localparam int INIT_BIT = 0;
   localparam logic [3:0] CHAN_LAST = 4'h9;
   localparam logic [3:0] CHAN_DIGITAL_LAST = 4'h1;
   localparam logic [7:0] AUX_PCT_MAX = 8'h96;
   localparam logic [15:0] PRESET_DEF = 16'h1388;
   localparam logic [15:0] MAX_FREQ_DEF = 16'h1388;
   localparam logic [15:0] MAX_LOW_DEC1 = 16'h01f4;
   localparam logic [15:0] MAX_HIGH_DEC1 = 16'h7d00;
   localparam logic [15:0] MAX_LOW_DEC2 = 16'h1388;
   localparam logic [15:0] MAX_HIGH_DEC2 = 16'hea60;
   localparam logic [1:0] DEC_ONE = 2'h1;
   localparam logic [1:0] DEC_TWO = 2'h2;
   localparam logic [47:0] PCT_FULL = 48'h3e8;
   localparam logic [47:0] PCT_UNIT = 48'h64;
   typedef logic signed [47:0] wide_type;
   typedef logic signed [31:0] val_type;
   typedef enum logic [2:0] {
      SEL_MAIN, SEL_COMBINED, SEL_X_Y, SEL_X_COMB, SEL_Y_COMB
   } pick_type;
   typedef enum logic [1:0] {OP_SUM, OP_DIFF, OP_MAX, OP_MIN} op_type;
endpackage
`default_nettype wire

// ### src/frequency_setpoint_composer.sv
// Purpose: Composes the drive's target frequency from main and auxiliary sources.
// Assumes: Avalon-MM master holds each request until waitrequest is low.
// Notes: Two register stages from source inputs to TARGET_FREQ.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none

// Functional notes
// [R1] Range base 0: max frequency, 1: main X
// [R2] Auxiliary range percent limited to 0..150
// [R3] Full-scale aux input maps to aux span
// [R4] Range settings apply only in units 1,3,4
// [R5] Units 0: target is main X
// [R6] Units 1: target is combined result
// [R7] Units 2: switch picks X or Y
// [R8] Units 3: switch picks X or combined
// [R9] Units 4: switch picks Y or combined
// [R10] Tens 0: combined is X plus Y
// [R11] Tens 1: combined is X minus Y
// [R12] Tens 2: larger absolute value wins
// [R13] Tens 3: smaller absolute value wins
// [R14] Offset is added to combined result
// [R15] Preset defaults 50.00 Hz, seeds digital sources
// [R16] Direction kept at 0, inverted at 1
// [R17] Parameter init restores non-inverted direction
// [R18] Percent sources scale to max frequency
// [R19] One decimal: max 50.0..3200.0 Hz
// [R20] Two decimals: max up to 600.00 Hz
// [R21] Avoid same channel for main and aux
// [R22] Each selector picks one of ten channels
// [R23] Digital aux in combination ignores preset
// [R24] Target saturated to zero..max frequency
module frequency_setpoint_composer #(
   parameter int PCT_W = 16
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic signed [PCT_W-1:0] ANALOG_IN_A,
   input wire logic signed [PCT_W-1:0] ANALOG_IN_B,
   input wire logic signed [PCT_W-1:0] ANALOG_IN_C,
   input wire logic signed [PCT_W-1:0] PULSE_INPUT_TERMINAL,
   input wire logic signed [PCT_W-1:0] MULTI_STEP,
   input wire logic signed [PCT_W-1:0] SEQUENCER,
   input wire logic signed [PCT_W-1:0] PID_OUT,
   input wire logic signed [PCT_W-1:0] COMM_SETPOINT,
   input wire logic signed [15:0] UPDOWN_ADJUST,
   input wire logic SOURCE_SWITCH,
   input wire logic DIRECTION_CMD,
   output logic [15:0] TARGET_FREQ,
   output logic DIRECTION_OUT,
   output logic [1:0] DECIMAL_PLACES
);

   logic [3:0] main_source_select;
   logic [3:0] aux_source_select;
   logic aux_range_base;
   logic [7:0] aux_range_percent;
   composer_pkg::pick_type pick;
   composer_pkg::op_type op;
   logic [15:0] preset_setpoint;
   logic direction_invert;
   logic [15:0] max_output_frequency;
   logic signed [15:0] composition_offset;
   logic [3:0] next_main_sel;
   logic [3:0] next_aux_sel;
   logic next_aux_base;
   logic [7:0] next_aux_pct;
   composer_pkg::pick_type next_pick;
   composer_pkg::op_type next_op;
   logic [15:0] next_preset;
   logic next_dir_inv;
   logic [15:0] next_max_freq;
   logic signed [15:0] next_offset;
   logic [1:0] next_decimals;
   logic [31:0] next_readdata;
   logic next_wait;
   logic [31:0] rd_mux;
   logic [31:0] wd;
   logic wr_go;
   logic [7:0] word_addr;
   composer_pkg::val_type x_q;
   composer_pkg::val_type y_q;
   logic sw_q;
   composer_pkg::val_type next_x;
   composer_pkg::val_type next_y;
   logic [15:0] next_target;
   logic next_dir_out;
   composer_pkg::wide_type chan [10];
   composer_pkg::val_type sum_chk;
   composer_pkg::val_type diff_chk;

   function automatic logic [15:0] clamp_max(input logic [15:0] v, input logic [1:0] dec);
      logic [15:0] lo;
      logic [15:0] hi;
      lo = (dec == composer_pkg::DEC_ONE) ? composer_pkg::MAX_LOW_DEC1 :
         composer_pkg::MAX_LOW_DEC2;
      hi = (dec == composer_pkg::DEC_ONE) ? composer_pkg::MAX_HIGH_DEC1 :
         composer_pkg::MAX_HIGH_DEC2;
      if (v < lo) begin
         clamp_max = lo;
      end else if (v > hi) begin
         clamp_max = hi;
      end else begin
         clamp_max = v;
      end
   endfunction

   function automatic composer_pkg::val_type abs_v(input composer_pkg::val_type v);
      abs_v = (v < 0) ? -v : v;
   endfunction

   assign word_addr = {AVS_ADDRESS[7:2], 2'h0};
   assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;

   // Readback mux, also the base for byte-lane merging on writes
   always_comb begin
      rd_mux = 32'h0;
      unique case (word_addr)
         composer_pkg::OFS_MAIN_SEL: rd_mux[3:0] = main_source_select;
         composer_pkg::OFS_AUX_SEL: rd_mux[3:0] = aux_source_select;
         composer_pkg::OFS_AUX_BASE: rd_mux[0] = aux_range_base;
         composer_pkg::OFS_AUX_PCT: rd_mux[7:0] = aux_range_percent;
         composer_pkg::OFS_COMPOSE: begin
            rd_mux[composer_pkg::UNITS_LSB +: 3] = pick;
            rd_mux[composer_pkg::TENS_LSB +: 2] = op;
         end
         composer_pkg::OFS_PRESET: rd_mux[15:0] = preset_setpoint;
         composer_pkg::OFS_DIR_INV: rd_mux[0] = direction_invert;
         composer_pkg::OFS_MAX_FREQ: rd_mux[15:0] = max_output_frequency;
         composer_pkg::OFS_OFFSET: rd_mux[15:0] = composition_offset;
         composer_pkg::OFS_DECIMALS: rd_mux[1:0] = DECIMAL_PLACES;
         composer_pkg::OFS_TARGET: rd_mux[15:0] = TARGET_FREQ;
         composer_pkg::OFS_STATUS: rd_mux[1:0] = {sw_q, DIRECTION_OUT};
         default: rd_mux = 32'h0;
      endcase
      for (int i = 0; i < 4; i++) begin
         wd[8*i +: 8] = AVS_BYTEENABLE[i] ? AVS_WRITEDATA[8*i +: 8] : rd_mux[8*i +: 8];
      end
   end

   // One wait cycle per access; read data loaded as waitrequest drops
   always_comb begin
      next_wait = !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      next_readdata = AVS_READDATA;
      if (AVS_READ && AVS_WAITREQUEST) begin
         next_readdata = rd_mux;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h0;
      end else begin
         AVS_WAITREQUEST <= next_wait;
         AVS_READDATA <= next_readdata;
      end
   end

   // Settings; illegal codes are dropped so the enums never hold them
   always_comb begin
      next_main_sel = main_source_select;
      next_aux_sel = aux_source_select;
      next_aux_base = aux_range_base;
      next_aux_pct = aux_range_percent;
      next_pick = pick;
      next_op = op;
      next_preset = preset_setpoint;
      next_dir_inv = direction_invert;
      next_max_freq = max_output_frequency;
      next_offset = composition_offset;
      next_decimals = DECIMAL_PLACES;
      if (wr_go) begin
         unique case (word_addr)
            composer_pkg::OFS_MAIN_SEL: begin
               if (wd[3:0] <= composer_pkg::CHAN_LAST) begin
                  next_main_sel = wd[3:0]; // R22
               end
            end
            composer_pkg::OFS_AUX_SEL: begin
               if (wd[3:0] <= composer_pkg::CHAN_LAST) begin
                  next_aux_sel = wd[3:0]; // R22
               end
            end
            composer_pkg::OFS_AUX_BASE: next_aux_base = wd[0]; // R1
            composer_pkg::OFS_AUX_PCT: begin
               next_aux_pct = (wd[7:0] > composer_pkg::AUX_PCT_MAX) ?
                  composer_pkg::AUX_PCT_MAX : wd[7:0]; // R2
            end
            composer_pkg::OFS_COMPOSE: begin
               if (wd[composer_pkg::UNITS_LSB +: 3] <= 3'(composer_pkg::SEL_Y_COMB)) begin
                  next_pick = composer_pkg::pick_type'(wd[composer_pkg::UNITS_LSB +: 3]);
               end
               next_op = composer_pkg::op_type'(wd[composer_pkg::TENS_LSB +: 2]);
            end
            composer_pkg::OFS_PRESET: begin
               next_preset = (wd[15:0] > max_output_frequency) ?
                  max_output_frequency : wd[15:0];
            end
            composer_pkg::OFS_DIR_INV: next_dir_inv = wd[0]; // R16
            composer_pkg::OFS_MAX_FREQ: begin
               next_max_freq = clamp_max(wd[15:0], DECIMAL_PLACES); // R19 R20
            end
            composer_pkg::OFS_OFFSET: next_offset = wd[15:0];
            composer_pkg::OFS_DECIMALS: begin
               if (wd[1:0] == composer_pkg::DEC_ONE || wd[1:0] == composer_pkg::DEC_TWO) begin
                  next_decimals = wd[1:0];
                  next_max_freq = clamp_max(max_output_frequency, wd[1:0]); // R19 R20
               end
            end
            composer_pkg::OFS_CONTROL: begin
               if (wd[composer_pkg::INIT_BIT]) begin
                  next_main_sel = 4'h0;
                  next_aux_sel = 4'h0;
                  next_aux_base = 1'b0;
                  next_aux_pct = 8'h0;
                  next_pick = composer_pkg::SEL_MAIN;
                  next_op = composer_pkg::OP_SUM;
                  next_preset = composer_pkg::PRESET_DEF; // R15
                  next_dir_inv = 1'b0; // R17
                  next_max_freq = composer_pkg::MAX_FREQ_DEF;
                  next_offset = 16'sh0;
                  next_decimals = composer_pkg::DEC_TWO;
               end
            end
            default: begin
            end
         endcase
         if (next_preset > next_max_freq) begin
            next_preset = next_max_freq;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         main_source_select <= 4'h0;
         aux_source_select <= 4'h0;
         aux_range_base <= 1'b0;
         aux_range_percent <= 8'h0;
         pick <= composer_pkg::SEL_MAIN;
         op <= composer_pkg::OP_SUM;
         preset_setpoint <= composer_pkg::PRESET_DEF; // R15
         direction_invert <= 1'b0;
         max_output_frequency <= composer_pkg::MAX_FREQ_DEF;
         composition_offset <= 16'sh0;
         DECIMAL_PLACES <= composer_pkg::DEC_TWO;
      end else begin
         main_source_select <= next_main_sel;
         aux_source_select <= next_aux_sel;
         aux_range_base <= next_aux_base;
         aux_range_percent <= next_aux_pct;
         pick <= next_pick;
         op <= next_op;
         preset_setpoint <= next_preset;
         direction_invert <= next_dir_inv;
         max_output_frequency <= next_max_freq;
         composition_offset <= next_offset;
         DECIMAL_PLACES <= next_decimals;
      end
   end

   // Stage one: turn channel values into X and Y frequencies
   always_comb begin
      composer_pkg::wide_type maxw;
      composer_pkg::wide_type basew;
      composer_pkg::wide_type span;
      composer_pkg::wide_type dig;
      logic combining;
      basew = 48'sh0;
      span = 48'sh0;
      combining = 1'b0;
      maxw = composer_pkg::wide_type'({32'h0, max_output_frequency});
      dig = composer_pkg::wide_type'({32'h0, preset_setpoint}) +
         composer_pkg::wide_type'(UPDOWN_ADJUST);
      chan[0] = 48'sh0;
      chan[1] = 48'sh0;
      chan[2] = composer_pkg::wide_type'(ANALOG_IN_A);
      chan[3] = composer_pkg::wide_type'(ANALOG_IN_B);
      chan[4] = composer_pkg::wide_type'(ANALOG_IN_C);
      chan[5] = composer_pkg::wide_type'(PULSE_INPUT_TERMINAL);
      chan[6] = composer_pkg::wide_type'(MULTI_STEP);
      chan[7] = composer_pkg::wide_type'(SEQUENCER);
      chan[8] = composer_pkg::wide_type'(PID_OUT);
      chan[9] = composer_pkg::wide_type'(COMM_SETPOINT);
      combining = (pick == composer_pkg::SEL_COMBINED) ||
         (pick == composer_pkg::SEL_X_COMB) || (pick == composer_pkg::SEL_Y_COMB); // R4
      if (main_source_select <= composer_pkg::CHAN_DIGITAL_LAST) begin
         next_x = 32'(dig); // R15
      end else begin
         next_x = 32'(chan[main_source_select] * maxw /
            signed'(composer_pkg::PCT_FULL)); // R18
      end
      basew = aux_range_base ? composer_pkg::wide_type'(abs_v(next_x)) : maxw; // R1
      span = basew * composer_pkg::wide_type'({40'h0, aux_range_percent}) /
         signed'(composer_pkg::PCT_UNIT); // R2
      if (aux_source_select <= composer_pkg::CHAN_DIGITAL_LAST) begin
         // Digital aux rides on X as a pure trim when combined
         next_y = combining ? 32'(UPDOWN_ADJUST) : 32'(dig); // R23
      end else if (combining) begin
         next_y = 32'(chan[aux_source_select] * span /
            signed'(composer_pkg::PCT_FULL)); // R3
      end else begin
         next_y = 32'(chan[aux_source_select] * maxw /
            signed'(composer_pkg::PCT_FULL)); // R18
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         x_q <= 32'sh0;
         y_q <= 32'sh0;
         sw_q <= 1'b0;
      end else begin
         x_q <= next_x;
         y_q <= next_y;
         sw_q <= SOURCE_SWITCH;
      end
   end

   // Stage two: compose, pick and saturate
   always_comb begin
      composer_pkg::val_type comb_r;
      composer_pkg::val_type chosen;
      comb_r = 32'sh0;
      chosen = 32'sh0;
      sum_chk = x_q + y_q + 32'(composition_offset);
      diff_chk = x_q - y_q + 32'(composition_offset);
      unique case (op)
         composer_pkg::OP_SUM: comb_r = x_q + y_q; // R10
         composer_pkg::OP_DIFF: comb_r = x_q - y_q; // R11
         composer_pkg::OP_MAX: comb_r = (abs_v(x_q) >= abs_v(y_q)) ? x_q : y_q; // R12
         composer_pkg::OP_MIN: comb_r = (abs_v(x_q) <= abs_v(y_q)) ? x_q : y_q; // R13
      endcase
      comb_r = comb_r + 32'(composition_offset); // R14
      unique case (pick)
         composer_pkg::SEL_MAIN: chosen = x_q; // R5
         composer_pkg::SEL_COMBINED: chosen = comb_r; // R6
         composer_pkg::SEL_X_Y: chosen = sw_q ? y_q : x_q; // R7
         composer_pkg::SEL_X_COMB: chosen = sw_q ? comb_r : x_q; // R8
         composer_pkg::SEL_Y_COMB: chosen = sw_q ? comb_r : y_q; // R9
      endcase
      // Negative results clamp to zero; direction comes only from DIRECTION_CMD and direction_invert
      if (chosen < 0) begin
         next_target = 16'h0; // R24
      end else if (chosen > 32'({16'h0, max_output_frequency})) begin
         next_target = max_output_frequency; // R24
      end else begin
         next_target = chosen[15:0];
      end
      next_dir_out = DIRECTION_CMD ^ direction_invert; // R16
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TARGET_FREQ <= 16'h0;
         DIRECTION_OUT <= 1'b0;
      end else begin
         TARGET_FREQ <= next_target;
         DIRECTION_OUT <= next_dir_out;
      end
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   target_cap_a: assert property ( // R24
      TARGET_FREQ <= $past(max_output_frequency))
      else $error("target above max frequency");
   main_only_a: assert property ( // R5
      (pick == composer_pkg::SEL_MAIN && x_q >= 0 && x_q <= 32'(max_output_frequency))
      |=> TARGET_FREQ == $past(x_q[15:0]))
      else $error("main-only mode not following X");
   switch_xy_a: assert property ( // R7
      (pick == composer_pkg::SEL_X_Y && sw_q && y_q >= 0 &&
      y_q <= 32'(max_output_frequency)) |=> TARGET_FREQ == $past(y_q[15:0]))
      else $error("switch did not select Y");
   sum_offset_a: assert property ( // R10
      (pick == composer_pkg::SEL_COMBINED && op == composer_pkg::OP_SUM &&
      sum_chk >= 0 && sum_chk <= 32'(max_output_frequency))
      |=> TARGET_FREQ == $past(sum_chk[15:0]))
      else $error("sum plus offset wrong");
   diff_offset_a: assert property ( // R11
      (pick == composer_pkg::SEL_X_COMB && sw_q && op == composer_pkg::OP_DIFF &&
      diff_chk >= 0 && diff_chk <= 32'(max_output_frequency))
      |=> TARGET_FREQ == $past(diff_chk[15:0]))
      else $error("difference plus offset wrong");
   max_abs_a: assert property ( // R12
      (pick == composer_pkg::SEL_COMBINED && op == composer_pkg::OP_MAX &&
      composition_offset == 0 && x_q >= 0 && y_q >= 0 &&
      x_q <= 32'(max_output_frequency) && y_q <= 32'(max_output_frequency))
      |=> TARGET_FREQ == $past(x_q > y_q ? x_q[15:0] : y_q[15:0]))
      else $error("max of the two wrong");
   min_abs_a: assert property ( // R13
      (pick == composer_pkg::SEL_Y_COMB && sw_q && op == composer_pkg::OP_MIN &&
      composition_offset == 0 && x_q >= 0 && y_q >= 0 &&
      x_q <= 32'(max_output_frequency) && y_q <= 32'(max_output_frequency))
      |=> TARGET_FREQ == $past(x_q < y_q ? x_q[15:0] : y_q[15:0]))
      else $error("min of the two wrong");
   dir_invert_a: assert property ( // R16
      direction_invert |=> DIRECTION_OUT != $past(DIRECTION_CMD))
      else $error("direction not inverted");
   init_restore_a: assert property ( // R17
      (wr_go && word_addr == composer_pkg::OFS_CONTROL &&
      AVS_BYTEENABLE[0] && AVS_WRITEDATA[composer_pkg::INIT_BIT])
      |=> !direction_invert && preset_setpoint == composer_pkg::PRESET_DEF)
      else $error("init did not restore defaults");
   pct_cap_a: assert property ( // R2
      aux_range_percent <= composer_pkg::AUX_PCT_MAX)
      else $error("aux range percent above 150");
   max_range_a: assert property ( // R20
      DECIMAL_PLACES == composer_pkg::DEC_TWO |->
      max_output_frequency <= composer_pkg::MAX_HIGH_DEC2 &&
      max_output_frequency >= composer_pkg::MAX_LOW_DEC2)
      else $error("max frequency outside two-decimal range");
   max_dec1_a: assert property ( // R19
      DECIMAL_PLACES == composer_pkg::DEC_ONE |->
      max_output_frequency <= composer_pkg::MAX_HIGH_DEC1 &&
      max_output_frequency >= composer_pkg::MAX_LOW_DEC1)
      else $error("max frequency outside one-decimal range");

endmodule
`default_nettype wire

// ### tb/setpoint_sources.sv
// Purpose: Far-side model of the analog, pulse and switch setpoint sources.
// Assumes: Percent values in 0.1 % steps, 1000 is full scale.
// Notes: Outputs change one edge after the bench asks, like sampled front ends.
`default_nettype none
module setpoint_sources (
   input wire logic clk,
   input wire logic signed [15:0] set_a,
   input wire logic signed [15:0] set_b,
   input wire logic set_sw,
   output logic signed [15:0] ana_a,
   output logic signed [15:0] ana_b,
   output logic signed [15:0] ana_c,
   output logic signed [15:0] pulse,
   output logic sw
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk) begin
      ana_a <= set_a;
      ana_b <= set_b;
      ana_c <= -set_a;
      pulse <= ~set_b;
      sw <= set_sw;
   end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench of the frequency setpoint composer.
// Assumes: One wait state per bus access, target two edges behind inputs.
// Notes: Main uses channels 0 and 2, aux 1 and 3, never the same channel.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0;
   logic rst_n = 0;
   logic [7:0] adr = 8'h00;
   logic rd = 0;
   logic wr = 0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic [31:0] avs_rd;
   logic avs_wait;
   logic [15:0] tgt;
   logic dir_out;
   logic [1:0] dec;
   logic signed [15:0] set_a = 0;
   logic signed [15:0] set_b = 0;
   logic signed [15:0] ud = 0;
   logic set_sw = 0;
   logic dcmd = 0;
   wire logic signed [15:0] a_in, b_in, c_in, p_in;
   wire logic sw_in;
   logic [31:0] st = 32'd39;
   int bad_count = 0;
   int n_checks = 0;
   int mx, pre, ofs, base, pct, msel, asel, un, tn;
   always #2 clk = ~clk;
   setpoint_sources i_src (.clk(clk), .set_a(set_a), .set_b(set_b), .set_sw(set_sw),
      .ana_a(a_in), .ana_b(b_in), .ana_c(c_in), .pulse(p_in), .sw(sw_in));
   frequency_setpoint_composer i_dut (.SYS_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
      .AVS_READDATA(avs_rd), .AVS_WAITREQUEST(avs_wait), .ANALOG_IN_A(a_in),
      .ANALOG_IN_B(b_in), .ANALOG_IN_C(c_in), .PULSE_INPUT_TERMINAL(p_in),
      .MULTI_STEP(16'sh0), .SEQUENCER(16'sh0), .PID_OUT(16'sh0), .COMM_SETPOINT(16'sh0),
      .UPDOWN_ADJUST(ud), .SOURCE_SWITCH(sw_in), .DIRECTION_CMD(dcmd),
      .TARGET_FREQ(tgt), .DIRECTION_OUT(dir_out), .DECIMAL_PLACES(dec));
   function automatic int rnd(int lim);
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return int'(st % lim);
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Holds the request until waitrequest is sampled low, bounded in case it never comes
   task automatic bus(bit w, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      // Look at waitrequest mid-cycle, where it has settled, then take the answering edge
      do begin
         @(negedge clk);
         n++;
      end while (avs_wait !== 1'b0 && n < 20);
      if (n >= 20) chk("bus answer", 32'h1, 32'h0);
      @(posedge clk);
      rdata = avs_rd;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   function automatic int expect_target(int a, int b, int u, bit s);
      int x, y, c, ax, ay, t, span;
      x = (msel < 2) ? pre + u : a * mx / 1000;
      ax = (x < 0) ? -x : x;
      if (un == 1 || un == 3 || un == 4) begin
         span = (base != 0 ? ax : mx) * pct / 100;
         y = (asel < 2) ? u : b * span / 1000;
      end else begin
         y = (asel < 2) ? pre + u : b * mx / 1000;
      end
      ay = (y < 0) ? -y : y;
      case (tn)
         0: c = x + y;
         1: c = x - y;
         2: c = (ay > ax) ? y : x;
         default: c = (ay < ax) ? y : x;
      endcase
      c += ofs;
      case (un)
         0: t = x;
         1: t = c;
         2: t = s ? y : x;
         3: t = s ? c : x;
         default: t = s ? c : y;
      endcase
      return (t < 0) ? 0 : ((t > mx) ? mx : t);
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      results();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, composer_pkg::OFS_PRESET, 0);
      chk("preset", rdata, {16'h0, composer_pkg::PRESET_DEF});
      bus(0, composer_pkg::OFS_MAX_FREQ, 0);
      chk("max", rdata, 32'd5000);
      bus(0, 8'hfc, 0);
      chk("unmapped", rdata, 32'h0);
      chk("decimals", {30'h0, dec}, 32'h2);
      $display("reset test done");
      for (int i = 0; i < 40; i++) begin
         un = i % 5;
         tn = (i / 5) % 4;
         msel = (i % 2 != 0) ? 2 : 0;
         asel = (i % 3 == 0) ? 1 : 3;
         base = (i / 2) % 2;
         pct = rnd(151);
         ofs = rnd(201) - 100;
         mx = 5000 + rnd(55001);
         pre = rnd(mx + 1);
         bus(1, composer_pkg::OFS_MAIN_SEL, 32'(msel));
         bus(1, composer_pkg::OFS_AUX_SEL, 32'(asel));
         bus(1, composer_pkg::OFS_AUX_BASE, 32'(base));
         bus(1, composer_pkg::OFS_AUX_PCT, 32'(pct));
         bus(1, composer_pkg::OFS_COMPOSE, 32'(tn * 16 + un));
         bus(1, composer_pkg::OFS_MAX_FREQ, 32'(mx));
         bus(1, composer_pkg::OFS_PRESET, 32'(pre));
         bus(1, composer_pkg::OFS_OFFSET, {16'h0, 16'(ofs)});
         set_a <= 16'(rnd(1001));
         set_b <= 16'(rnd(2001) - 1000);
         ud <= 16'(rnd(201) - 100);
         set_sw <= rnd(2) != 0;
         repeat (4) @(posedge clk);
         chk("target", {16'h0, tgt}, 32'(expect_target(set_a, set_b, ud, set_sw)));
      end
      $display("compose test done");
      bus(1, composer_pkg::OFS_DIR_INV, 32'h1);
      dcmd <= 1'b1;
      repeat (2) @(posedge clk);
      chk("direction", {31'h0, dir_out}, 32'h0);
      bus(1, composer_pkg::OFS_CONTROL, 32'h1);
      repeat (2) @(posedge clk);
      chk("direction init", {31'h0, dir_out}, 32'h1);
      bus(0, composer_pkg::OFS_DIR_INV, 0);
      chk("invert init", rdata, 32'h0);
      $display("direction test done");
      for (int d = 1; d <= 2; d++) begin
         bus(1, composer_pkg::OFS_DECIMALS, 32'(d));
         bus(1, composer_pkg::OFS_MAX_FREQ, 32'hffff);
         bus(0, composer_pkg::OFS_MAX_FREQ, 0);
         chk("max clamp", rdata, (d == 1) ? 32'd32000 : 32'd60000);
         chk("decimals pin", {30'h0, dec}, 32'(d));
      end
      $display("resolution test done");
      results();
   end
endmodule
`default_nettype wire
